// ===== design/oxe_pkg.sv
// Package: constants for the OR/shift/move/indirect execution block
package oxe_pkg;
  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [4:0] OFS_CMD = 5'h00;
  localparam logic [4:0] OFS_ACC = 5'h04;
  localparam logic [4:0] OFS_STAT = 5'h08;
  localparam logic [4:0] OFS_PTR0 = 5'h0c;
  localparam logic [4:0] OFS_PTR1 = 5'h10;
  localparam logic [4:0] OFS_MIDX = 5'h14;
  localparam logic [4:0] OFS_MDAT = 5'h18;
  // ****************************************
  // Command word fields
  // ****************************************
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_D_BIT = 3;
  localparam int CMD_F_LSB = 4;
  localparam int CMD_N_BIT = 11;
  localparam int CMD_MODE_LSB = 12;
  localparam int CMD_REL_BIT = 14;
  localparam int CMD_K_LSB = 15;
  // ****************************************
  // Status bits
  // ****************************************
  localparam int STAT_C_BIT = 0;
  localparam int STAT_Z_BIT = 1;
  // ****************************************
  // Opcodes and pointer modes
  // ****************************************
  typedef enum logic [2:0] {
    OP_OR = 3'h0,
    OP_LSL = 3'h1,
    OP_LSR = 3'h2,
    OP_MOVE_FILE = 3'h3,
    OP_IND_LOAD = 3'h4
  } oxe_op_t;
  localparam logic [1:0] MODE_PREINC = 2'h0;
  localparam logic [1:0] MODE_PREDEC = 2'h1;
  localparam logic [1:0] MODE_POSTINC = 2'h2;
  localparam logic [1:0] MODE_POSTDEC = 2'h3;
  // ****************************************
  // Sizes and reset values
  // ****************************************
  localparam int MEM_DEPTH = 128;
  localparam logic [6:0] WIN0_ADDR = 7'h00;
  localparam logic [6:0] WIN1_ADDR = 7'h01;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [15:0] PTR_RST = 16'h0000;
  localparam logic [7:0] MEM_RST = 8'h00;
endpackage

// ===== design/oxe_exec.sv
// Execution unit: OR, shifts, move-file and indirect load behind Wishbone
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// [RQ1] OR accumulator with file, d picks destination
// [RQ2] File field 0..127, select bit 0 or 1
// [RQ3] Left shift: bit7 to carry, zero in
// [RQ4] Right shift: zero in, bit0 to carry
// [RQ5] Move file to acc or itself, one cycle
// [RQ6] Move to itself keeps data, sets zero
// [RQ7] Indirect load modes pre/post inc/dec
// [RQ8] One-bit index picks one of two pointers
// [RQ9] Relative form: pointer plus signed offset
// [RQ10] Pointer after load: plus, minus or same
// [RQ11] Window registers access memory via pointer
// [RQ12] Pointers sixteen bits, wrap modulo 65536
// [RQ13] Zero flag set exactly when result zero
module oxe_exec (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [4:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o
);

  // ****************************************
  // Functions
  // ****************************************
  function automatic logic [6:0] resolve(input logic [6:0] f, input logic [15:0] p0,
                                         input logic [15:0] p1);
    if (f == oxe_pkg::WIN0_ADDR)
      resolve = p0[6:0];
    else if (f == oxe_pkg::WIN1_ADDR)
      resolve = p1[6:0];
    else
      resolve = f;
  endfunction

  function automatic logic zero_of(input logic [7:0] v);
    zero_of = (v == 8'h00);
  endfunction

  // ****************************************
  // State
  // ****************************************
  logic [7:0] mem_r [oxe_pkg::MEM_DEPTH];
  logic [7:0] acc_r;
  logic c_r;
  logic z_r;
  logic [15:0] ptr0_r;
  logic [15:0] ptr1_r;
  logic [6:0] midx_r;
  logic ack_r;
  logic [31:0] dat_r;

  // ****************************************
  // Bus decode
  // ****************************************
  logic acc_go;
  logic wr_go;
  assign acc_go = cyc_i && stb_i && !ack_r;
  assign wr_go = acc_go && we_i;
  assign ack_o = ack_r;
  assign dat_o = dat_r;

  // ****************************************
  // Command decode
  // ****************************************
  logic cmd_go;
  logic [2:0] op;
  logic dsel;
  logic [6:0] fadr;
  logic pn;
  logic [1:0] pmode;
  logic prel;
  logic [5:0] koff;
  assign cmd_go = wr_go && adr_i == oxe_pkg::OFS_CMD && sel_i[0];
  assign op = dat_i[oxe_pkg::CMD_OP_LSB +: 3];
  assign dsel = dat_i[oxe_pkg::CMD_D_BIT]; // [RQ2]
  assign fadr = dat_i[oxe_pkg::CMD_F_LSB +: 7]; // [RQ2]
  assign pn = dat_i[oxe_pkg::CMD_N_BIT];
  assign pmode = dat_i[oxe_pkg::CMD_MODE_LSB +: 2];
  assign prel = dat_i[oxe_pkg::CMD_REL_BIT];
  assign koff = dat_i[oxe_pkg::CMD_K_LSB +: 6];

  // ****************************************
  // Datapath
  // ****************************************
  logic [6:0] fidx;
  logic [7:0] fval;
  logic [15:0] psel;
  logic [15:0] ea;
  logic [15:0] pnew;
  logic [7:0] res;
  logic res_c;
  logic c_upd;
  logic to_file;
  logic to_acc;
  logic op_ok;

  assign fidx = resolve(fadr, ptr0_r, ptr1_r); // [RQ11]
  assign fval = mem_r[fidx];
  assign psel = pn ? ptr1_r : ptr0_r; // [RQ8]

  always_comb
  begin
    ea = psel;
    pnew = psel;
    if (prel)
    begin
      ea = psel + {{10{koff[5]}}, koff}; // [RQ9] [RQ12]
    end
    else
    begin
      case (pmode) // [RQ7]
        oxe_pkg::MODE_PREINC:
        begin
          ea = psel + 16'h0001;
          pnew = psel + 16'h0001; // [RQ10] [RQ12]
        end
        oxe_pkg::MODE_PREDEC:
        begin
          ea = psel - 16'h0001;
          pnew = psel - 16'h0001; // [RQ10] [RQ12]
        end
        oxe_pkg::MODE_POSTINC:
          pnew = psel + 16'h0001; // [RQ10]
        oxe_pkg::MODE_POSTDEC:
          pnew = psel - 16'h0001; // [RQ10]
        default:
          pnew = psel;
      endcase
    end
  end

  always_comb
  begin
    res = fval;
    res_c = c_r;
    c_upd = 1'b0;
    op_ok = 1'b1;
    case (op)
      oxe_pkg::OP_OR:
        res = acc_r | fval; // [RQ1]
      oxe_pkg::OP_LSL:
      begin
        res = {fval[6:0], 1'b0}; // [RQ3]
        res_c = fval[7];
        c_upd = 1'b1;
      end
      oxe_pkg::OP_LSR:
      begin
        res = {1'b0, fval[7:1]}; // [RQ4]
        res_c = fval[0];
        c_upd = 1'b1;
      end
      oxe_pkg::OP_MOVE_FILE:
        res = fval; // [RQ5] [RQ6]
      oxe_pkg::OP_IND_LOAD:
        res = mem_r[ea[6:0]]; // [RQ7]
      default:
        op_ok = 1'b0;
    endcase
  end

  assign to_file = cmd_go && op_ok && dsel && op != oxe_pkg::OP_IND_LOAD;
  assign to_acc = cmd_go && op_ok && (!dsel || op == oxe_pkg::OP_IND_LOAD);

  // ****************************************
  // Data memory
  // ****************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < oxe_pkg::MEM_DEPTH; i++)
        mem_r[i] <= oxe_pkg::MEM_RST;
    end
    else if (to_file)
      mem_r[fidx] <= res; // [RQ1] [RQ6]
    else if (wr_go && adr_i == oxe_pkg::OFS_MDAT && sel_i[0])
      mem_r[resolve(midx_r, ptr0_r, ptr1_r)] <= dat_i[7:0]; // [RQ11]
  end

  // ****************************************
  // Accumulator
  // ****************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      acc_r <= oxe_pkg::ACC_RST;
    else if (to_acc)
      acc_r <= res; // [RQ1] [RQ5]
    else if (wr_go && adr_i == oxe_pkg::OFS_ACC && sel_i[0])
      acc_r <= dat_i[7:0];
  end

  // ****************************************
  // Flags
  // ****************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      c_r <= 1'b0;
      z_r <= 1'b0;
    end
    else if (cmd_go && op_ok)
    begin
      z_r <= zero_of(res); // [RQ13]
      if (c_upd)
        c_r <= res_c; // [RQ3] [RQ4]
    end
    else if (wr_go && adr_i == oxe_pkg::OFS_STAT && sel_i[0])
    begin
      c_r <= dat_i[oxe_pkg::STAT_C_BIT];
      z_r <= dat_i[oxe_pkg::STAT_Z_BIT];
    end
  end

  // ****************************************
  // File pointers
  // ****************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ptr0_r <= oxe_pkg::PTR_RST;
      ptr1_r <= oxe_pkg::PTR_RST;
    end
    else if (cmd_go && op == oxe_pkg::OP_IND_LOAD)
    begin
      if (pn)
        ptr1_r <= pnew; // [RQ8] [RQ10]
      else
        ptr0_r <= pnew; // [RQ8] [RQ10]
    end
    else if (wr_go && adr_i == oxe_pkg::OFS_PTR0)
    begin
      if (sel_i[0])
        ptr0_r[7:0] <= dat_i[7:0];
      if (sel_i[1])
        ptr0_r[15:8] <= dat_i[15:8];
    end
    else if (wr_go && adr_i == oxe_pkg::OFS_PTR1)
    begin
      if (sel_i[0])
        ptr1_r[7:0] <= dat_i[7:0];
      if (sel_i[1])
        ptr1_r[15:8] <= dat_i[15:8];
    end
  end

  // ****************************************
  // Memory index register
  // ****************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      midx_r <= 7'h00;
    else if (wr_go && adr_i == oxe_pkg::OFS_MIDX && sel_i[0])
      midx_r <= dat_i[6:0];
  end

  // ****************************************
  // Bus answer
  // ****************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_r <= 1'b0;
    else
      ack_r <= acc_go;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dat_r <= 32'h0000_0000;
    else if (acc_go && !we_i)
    begin
      case (adr_i)
        oxe_pkg::OFS_ACC: dat_r <= {24'h000000, acc_r};
        oxe_pkg::OFS_STAT: dat_r <= {30'h00000000, z_r, c_r};
        oxe_pkg::OFS_PTR0: dat_r <= {16'h0000, ptr0_r};
        oxe_pkg::OFS_PTR1: dat_r <= {16'h0000, ptr1_r};
        oxe_pkg::OFS_MIDX: dat_r <= {25'h0000000, midx_r};
        oxe_pkg::OFS_MDAT: dat_r <= {24'h000000, mem_r[resolve(midx_r, ptr0_r, ptr1_r)]};
        default: dat_r <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_cmd(logic [2:0] o, logic d);
    cmd_go && op == o && dsel == d;
  endsequence

  a_or_to_acc: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ1]
    s_cmd(oxe_pkg::OP_OR, 1'b0) |=> acc_r == ($past(acc_r) | $past(fval)))
    else $error("OR result not in accumulator");

  a_or_to_file: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ1]
    s_cmd(oxe_pkg::OP_OR, 1'b1) |=> acc_r == $past(acc_r) && c_r == $past(c_r))
    else $error("OR to file disturbed accumulator or carry");

  a_lsl_carry: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ3]
    s_cmd(oxe_pkg::OP_LSL, 1'b0) |=> c_r == $past(fval[7]) && acc_r == {$past(fval[6:0]), 1'b0})
    else $error("Left shift wrong");

  a_lsr_carry: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ4]
    s_cmd(oxe_pkg::OP_LSR, 1'b0) |=> c_r == $past(fval[0]) && acc_r == {1'b0, $past(fval[7:1])})
    else $error("Right shift wrong");

  a_move_self: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ6]
    s_cmd(oxe_pkg::OP_MOVE_FILE, 1'b1) |=> mem_r[$past(fidx)] == $past(fval)
      && z_r == ($past(fval) == 8'h00) && acc_r == $past(acc_r))
    else $error("Move to itself wrong");

  a_move_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ5]
    s_cmd(oxe_pkg::OP_MOVE_FILE, 1'b0) |=> acc_r == $past(fval) ##1 ack_o == 1'b0)
    else $error("Move to accumulator not done in one cycle");

  a_ptr_inc: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ10]
    cmd_go && op == oxe_pkg::OP_IND_LOAD && !prel && !pn && !pmode[0]
      |=> ptr0_r == $past(ptr0_r) + 16'h0001)
    else $error("Pointer not incremented");

  a_ptr_dec: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ12]
    cmd_go && op == oxe_pkg::OP_IND_LOAD && !prel && pn && pmode[0] && ptr1_r == 16'h0000
      |=> ptr1_r == 16'hffff)
    else $error("Pointer did not wrap");

  a_rel_keep: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ9]
    cmd_go && op == oxe_pkg::OP_IND_LOAD && prel
      |=> ptr0_r == $past(ptr0_r) && ptr1_r == $past(ptr1_r)
        && acc_r == $past(mem_r[ea[6:0]]))
    else $error("Relative load changed pointer or loaded wrong byte");

  a_zero_flag: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ13]
    cmd_go && op_ok |=> z_r == (($past(res)) == 8'h00))
    else $error("Zero flag mismatch");

  a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o)
    else $error("Ack held two cycles");

endmodule // oxe_exec

`default_nettype wire

// ===== testbench/oxe_exec_test.sv
// Self-checking testbench for the OR/shift/move/indirect execution block
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin error_cnt++; $display("wrong value t=%0t got %h want %h", $time, g, e); end end
module oxe_exec_test;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [4:0] adr_i = 5'h00;
  logic [3:0] sel_i = 4'h3;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic ack_o;
  int error_cnt = 0;
  int num_checks = 0;
  logic [7:0] mem_exp [128];
  logic [31:0] q;
  typedef struct {logic [31:0] cmd; logic [7:0] acc, mem, st, e_acc, e_mem, e_st;} oxe_row_t;
  oxe_row_t rows [8];

  oxe_exec dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o));

  initial
  begin
    forever #5 clk_i = ~clk_i;
  end

  // ****************************************
  // Helpers
  // ****************************************
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // One classic cycle, held until ack is sampled, then one idle cycle
  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack_o !== 1'b1 && n < 50);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    if (n >= 50)
    begin
      error_cnt++;
      finish_test();
    end
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask

  task automatic rd(input logic [4:0] a);
    wb(1'b0, a, 32'h0);
  endtask

  function automatic logic [31:0] mk(input logic [2:0] op, input logic d, input logic [6:0] f);
    mk = 32'h0;
    mk[2:0] = op;
    mk[oxe_pkg::CMD_D_BIT] = d;
    mk[oxe_pkg::CMD_F_LSB +: 7] = f;
  endfunction

  // Indirect load with expected address, data and pointer worked out here
  task automatic iload(input logic n, input logic [1:0] m, input logic r, input logic [5:0] k,
    input logic [15:0] p);
    logic [31:0] c;
    logic [15:0] ea;
    logic [15:0] np;
    logic [4:0] pa;
    logic [4:0] pb;
    pa = n ? oxe_pkg::OFS_PTR1 : oxe_pkg::OFS_PTR0;
    pb = n ? oxe_pkg::OFS_PTR0 : oxe_pkg::OFS_PTR1;
    ea = (m == oxe_pkg::MODE_PREINC) ? p + 16'h1 : (m == oxe_pkg::MODE_PREDEC) ? p - 16'h1 : p;
    np = (m == oxe_pkg::MODE_PREDEC || m == oxe_pkg::MODE_POSTDEC) ? p - 16'h1 : p + 16'h1;
    if (r)
    begin
      ea = p + {{10{k[5]}}, k};
      np = p;
    end
    c = mk(oxe_pkg::OP_IND_LOAD, 1'b0, 7'h0);
    c[oxe_pkg::CMD_N_BIT] = n;
    c[oxe_pkg::CMD_MODE_LSB +: 2] = m;
    c[oxe_pkg::CMD_REL_BIT] = r;
    c[oxe_pkg::CMD_K_LSB +: 6] = k;
    wr(pa, {16'h0, p});
    wr(pb, 32'h0042);
    wr(oxe_pkg::OFS_STAT, 32'h1);
    wr(oxe_pkg::OFS_CMD, c);
    rd(oxe_pkg::OFS_ACC);
    `CHK(q[7:0], mem_exp[ea[6:0]])
    rd(oxe_pkg::OFS_STAT);
    `CHK(q[1:0], {mem_exp[ea[6:0]] == 8'h0, 1'b1})
    rd(pa);
    `CHK(q[15:0], np)
    rd(pb);
    `CHK(q[15:0], 16'h0042)
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial
  begin
    rows[0] = '{mk(oxe_pkg::OP_OR, 1'b0, 7'h10), 8'h0f, 8'h30, 8'h1, 8'h3f, 8'h30, 8'h1};
    rows[1] = '{mk(oxe_pkg::OP_OR, 1'b1, 7'h7f), 8'h00, 8'h00, 8'h0, 8'h00, 8'h00, 8'h2};
    rows[2] = '{mk(oxe_pkg::OP_LSL, 1'b0, 7'h10), 8'h00, 8'h81, 8'h0, 8'h02, 8'h81, 8'h1};
    rows[3] = '{mk(oxe_pkg::OP_LSL, 1'b1, 7'h10), 8'h11, 8'h80, 8'h0, 8'h11, 8'h00, 8'h3};
    rows[4] = '{mk(oxe_pkg::OP_LSR, 1'b0, 7'h10), 8'h11, 8'h01, 8'h0, 8'h00, 8'h01, 8'h3};
    rows[5] = '{mk(oxe_pkg::OP_LSR, 1'b1, 7'h10), 8'h11, 8'h82, 8'h3, 8'h11, 8'h41, 8'h0};
    rows[6] = '{mk(oxe_pkg::OP_MOVE_FILE, 1'b0, 7'h10), 8'h55, 8'h00, 8'h1, 8'h00, 8'h00, 8'h3};
    rows[7] = '{mk(oxe_pkg::OP_MOVE_FILE, 1'b1, 7'h10), 8'h55, 8'ha5, 8'h2, 8'h55, 8'ha5, 8'h0};
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    foreach (rows[i])
    begin
      wr(oxe_pkg::OFS_ACC, {24'h0, rows[i].acc});
      wr(oxe_pkg::OFS_MIDX, {25'h0, rows[i].cmd[10:4]});
      wr(oxe_pkg::OFS_MDAT, {24'h0, rows[i].mem});
      wr(oxe_pkg::OFS_STAT, {24'h0, rows[i].st});
      wr(oxe_pkg::OFS_CMD, rows[i].cmd);
      rd(oxe_pkg::OFS_ACC);
      `CHK(q[7:0], rows[i].e_acc)
      rd(oxe_pkg::OFS_MDAT);
      `CHK(q[7:0], rows[i].e_mem)
      rd(oxe_pkg::OFS_STAT);
      `CHK(q[1:0], rows[i].e_st[1:0])
    end
    $display("table test done");
    mem_exp[0] = 8'h00;
    mem_exp[1] = 8'h00;
    for (int i = 2; i < 128; i++)
    begin
      wr(oxe_pkg::OFS_MIDX, i);
      wr(oxe_pkg::OFS_MDAT, i);
      mem_exp[i] = 8'(i);
    end
    wr(oxe_pkg::OFS_MIDX, 32'h30);
    wr(oxe_pkg::OFS_MDAT, 32'h0);
    mem_exp[8'h30] = 8'h00;
    for (int i = 0; i < 8; i++)
      iload(i[2], i[1:0], 1'b0, 6'h0, 16'h0005);
    iload(1'b0, oxe_pkg::MODE_PREDEC, 1'b0, 6'h0, 16'h0000);
    iload(1'b1, oxe_pkg::MODE_POSTINC, 1'b0, 6'h0, 16'hffff);
    iload(1'b1, oxe_pkg::MODE_POSTDEC, 1'b0, 6'h0, 16'h0000);
    iload(1'b0, oxe_pkg::MODE_PREINC, 1'b1, 6'h20, 16'h0010);
    iload(1'b1, oxe_pkg::MODE_POSTDEC, 1'b1, 6'h1f, 16'h0010);
    iload(1'b0, oxe_pkg::MODE_PREINC, 1'b0, 6'h0, 16'h002f);
    $display("indirect test done");
    wr(oxe_pkg::OFS_PTR0, 32'h0020);
    wr(oxe_pkg::OFS_MIDX, 32'h0);
    wr(oxe_pkg::OFS_MDAT, 32'h99);
    wr(oxe_pkg::OFS_MIDX, 32'h20);
    rd(oxe_pkg::OFS_MDAT);
    `CHK(q[7:0], 8'h99)
    wr(oxe_pkg::OFS_PTR1, 32'h0020);
    wr(oxe_pkg::OFS_CMD, mk(oxe_pkg::OP_MOVE_FILE, 1'b0, 7'h01));
    rd(oxe_pkg::OFS_ACC);
    `CHK(q[7:0], 8'h99)
    wr(oxe_pkg::OFS_CMD, mk(3'h5, 1'b0, 7'h10));
    rd(oxe_pkg::OFS_ACC);
    `CHK(q[7:0], 8'h99)
    wr(5'h1c, 32'hff);
    rd(5'h1c);
    `CHK(q, 32'h0)
    $display("window and refusal test done");
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(oxe_pkg::OFS_ACC);
    `CHK(q[7:0], oxe_pkg::ACC_RST)
    rd(oxe_pkg::OFS_STAT);
    `CHK(q[1:0], 2'h0)
    rd(oxe_pkg::OFS_PTR0);
    `CHK(q[15:0], oxe_pkg::PTR_RST)
    rd(oxe_pkg::OFS_PTR1);
    `CHK(q[15:0], oxe_pkg::PTR_RST)
    rd(oxe_pkg::OFS_MDAT);
    `CHK(q[7:0], oxe_pkg::MEM_RST)
    sel_i <= 4'h2;
    wr(oxe_pkg::OFS_PTR0, 32'h1234);
    wr(oxe_pkg::OFS_ACC, 32'h77);
    sel_i <= 4'h3;
    rd(oxe_pkg::OFS_PTR0);
    `CHK(q[15:0], 16'h1200)
    rd(oxe_pkg::OFS_ACC);
    `CHK(q[7:0], 8'h00)
    $display("reset and byte select test done");
    finish_test();
  end

  initial
  begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    finish_test();
  end
endmodule // oxe_exec_test
`default_nettype wire
